// ### bench/sta_link_partner.sv
// far terminal: repeats what it hears, or falls silent
// assumes one clock shared with the terminal; the line idles high
`timescale 1ns/1ps
module sta_link_partner (
    // clock and control
    input  wire logic clock,
    input  wire logic mute,
    // serial link
    input  wire logic txPin,
    output logic      rxPin
);
    // echo keeps the frame format intact; silence models a dead partner
    initial rxPin = 1'b1;
    always @(posedge clock) rxPin <= mute ? 1'b1 : txPin;
endmodule

// ### bench/sta_term_asserts.sv
// port-level checks of the terminal: register answers, process status, link idle
// assumes controlByte is held steady by the controller until acknowledged
`timescale 1ns/1ps
module sta_term_asserts #(
    parameter logic [15:0] TYPE_ID = 16'h0000, // arbitrary value
    parameter logic [15:0] FW_REV  = 16'h0000  // arbitrary value
) (
    // clock and resets
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        storeReset_n,
    // process image
    input wire logic [7:0]  controlByte,
    input wire logic [15:0] outputWord,
    input wire logic [7:0]  statusByte,
    input wire logic [15:0] inputWord,
    // serial link
    input wire logic        rxPin,
    input wire logic        txPin
);
    // one domain; the terminal restart silences every check
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // three quiet cycles after a new byte cover the slow store reads too
    a_write_ack: assert property (
        ($changed(controlByte) && controlByte[7:6] == 2'b11) ##1 $stable(controlByte) [*3]
        |-> statusByte == (controlByte & 8'hBF)) else $error("write acknowledge differs");
    a_read_echo: assert property (
        ($changed(controlByte) && controlByte[7:6] == 2'b10) ##1 $stable(controlByte) [*3]
        |-> statusByte == controlByte) else $error("read echo differs");
    a_type_read: assert property (
        ($changed(controlByte) && controlByte == 8'h88) ##1 $stable(controlByte) [*3]
        |-> inputWord == TYPE_ID) else $error("type word differs");
    a_fw_read: assert property (
        ($changed(controlByte) && controlByte == 8'h89) ##1 $stable(controlByte) [*3]
        |-> inputWord == FW_REV) else $error("revision word differs");
    a_key_read: assert property (
        ($changed(controlByte) && controlByte == 8'h9F) ##1 $stable(controlByte) [*3]
        |-> inputWord inside {16'h0000, 16'h1235}) else $error("key read neither zero nor key");
    a_proc_status: assert property (
        (!controlByte[7] && $stable(controlByte)) [*3] |-> statusByte[7:5] == 3'b000)
        else $error("process status top bits set");
    a_timeout_zero: assert property (
        (!controlByte[7] && $stable(controlByte)) [*3] ##0 statusByte[4] |-> inputWord == 16'h0000)
        else $error("input word not zero in timeout");
    a_boot_quiet: assert property (
        $rose(reset_n) |-> statusByte == 8'h00 && inputWord == 16'h0000 && txPin)
        else $error("outputs not quiet after restart");
    a_start_bit: assert property (
        $fell(txPin) |-> !txPin [*8]) else $error("start bit too short");
endmodule
bind sta_terminal sta_term_asserts #(.TYPE_ID(TYPE_ID), .FW_REV(FW_REV)) sta_term_asserts_i (
    .clock(clock), .reset_n(reset_n), .storeReset_n(storeReset_n),
    .controlByte(controlByte), .outputWord(outputWord), .statusByte(statusByte),
    .inputWord(inputWord), .rxPin(rxPin), .txPin(txPin));

// ### bench/tb_top.sv
// self-checking bench: register accesses against a queue-free model, then link traffic
// assumes the partner echoes the terminal's own frames when not muted
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] TYPE_ID = 16'h5A5A; // arbitrary value
    localparam logic [15:0] FW_REV  = 16'hC3C3; // arbitrary value
    logic        clock        = 1'b0;
    logic        reset_n      = 1'b0;
    logic        storeReset_n = 1'b0;
    logic        mute         = 1'b1;
    logic [7:0]  controlByte  = 8'h00;
    logic [15:0] outputWord   = 16'h0000;
    logic [7:0]  statusByte;
    logic [15:0] inputWord;
    logic        rxPin;
    logic        txPin;
    logic [31:0] seed         = 32'h042763FA;
    logic [5:0]  idx;
    int          fails        = 0;
    int          testsRun     = 0;
    int          mem[64];     // model of the stored registers
    bit          unlocked;    // model of the write lock
    logic [7:0]  linkStat     = 8'h00; // model of the process status byte
    sta_terminal #(.TICK_CYCLES(20), .TYPE_ID(TYPE_ID), .FW_REV(FW_REV)) sta_terminal_i (
        .clock(clock), .reset_n(reset_n), .storeReset_n(storeReset_n), .controlByte(controlByte),
        .outputWord(outputWord), .statusByte(statusByte), .inputWord(inputWord),
        .rxPin(rxPin), .txPin(txPin));
    sta_link_partner sta_link_partner_i (.clock(clock), .mute(mute), .txPin(txPin), .rxPin(rxPin));
    // 40 MHz clock
    initial forever #12.5 clock = ~clock;
    // xorshift source for data and indices
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(logic [15:0] got, logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task completeRun();
        $display("checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task tick(int n);
        repeat (n) @(posedge clock);
    endtask
    // one access; a process byte in between lets identical accesses repeat
    task acc(logic [7:0] ctrl, logic [15:0] word);
        logic [15:0] exp;
        int i;
        // the previous answer stays three more edges so the checker sees it
        tick(3);
        controlByte <= 8'h00;
        tick(3);
        controlByte <= ctrl;
        outputWord <= word;
        exp = 16'h0000;
        if (ctrl[6]) begin
            if (ctrl[5:0] == 6'h1F) unlocked = (word == 16'h1235);
            else if (ctrl[5:0] >= 6'h20 && unlocked) mem[ctrl[5:0]] = word;
        end else if (ctrl[5:0] == 6'h06) exp = {8'h00, linkStat};
        else if (ctrl[5:0] == 6'h08) exp = TYPE_ID;
        else if (ctrl[5:0] == 6'h09) exp = FW_REV;
        else if (ctrl[5:0] == 6'h1F) exp = unlocked ? 16'h1235 : 16'h0000;
        else if (ctrl[5:0] >= 6'h20) exp = 16'(mem[ctrl[5:0]]);
        for (i = 0; i < 8 && statusByte !== (ctrl & 8'hBF); i++) @(negedge clock);
        check({8'h00, statusByte}, {8'h00, ctrl & 8'hBF});
        if (!ctrl[6]) check(inputWord, exp);
        if (i == 8) completeRun();
    endtask
    // main sequence
    initial begin
        for (int k = 0; k < 64; k++) mem[k] = 0;
        mem[32] = 7;
        mem[33] = 3;
        mem[34] = 20;
        unlocked = 0;
        tick(5);
        reset_n <= 1'b1;
        storeReset_n <= 1'b1;
        tick(6);
        acc(8'h88, rnd());
        acc(8'h89, rnd());
        acc(8'h9F, rnd());
        acc(8'hE0, 16'h0000);
        acc(8'hA0, rnd());
        acc(8'hC8, 16'hFFFF);
        acc(8'h88, 16'h0000);
        acc(8'hDF, 16'h1235);
        acc(8'h9F, rnd());
        repeat (12) begin
            idx = 6'(35 + rnd() % 29);
            acc({2'b11, idx}, rnd());
            acc({2'b10, idx}, rnd());
        end
        acc(8'hE0, 16'h0000);
        // silent partner: the old timeout setting is still in force
        @(posedge clock);
        controlByte <= 8'h00;
        tick(1000);
        @(negedge clock);
        check({8'h00, statusByte & 8'hF0}, 16'h0010);
        check(inputWord, 16'h0000);
        // diagnostic register shows the same process status
        linkStat = 8'h10;
        acc(8'h86, rnd());
        acc(8'hDF, 16'h0001);
        acc(8'h9F, 16'h0000);
        acc(8'hE5, 16'hBEEF);
        acc(8'hA5, 16'h0000);
        // restart only: the store survives and the new feature word applies
        @(posedge clock);
        reset_n <= 1'b0;
        // echo starts while the line idles, so the receiver locks on start bits
        mute <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        unlocked = 0;
        tick(6);
        acc(8'hA0, rnd());
        @(posedge clock);
        controlByte <= 8'h00;
        tick(1000);
        @(negedge clock);
        check({8'h00, statusByte}, 16'h0000);
        // echoed frames bring the sent word back
        @(posedge clock);
        outputWord <= 16'hA5C3;
        for (int i = 0; i < 70000 && inputWord !== 16'hA5C3; i++) @(negedge clock);
        check(inputWord, 16'hA5C3);
        @(negedge clock);
        check({8'h00, statusByte}, 16'h0000);
        completeRun();
    end
endmodule

// ### src/sta_defines.svh
// offsets, field positions, reset values and timing counts
// assumes a 40 MHz terminal clock
// Function
// - control bit 7 selects register access
// - control bit 6: zero read, one write
// - bits 5..0 index 64 registers
// - control byte first, then value high, low
// - read answer echoes control, returns value
// - write answer clears bit 6
// - read ignores the output word
// - user registers locked except index 31
// - key 0x1235 into 31 unlocks
// - other value into 31 relocks
// - unlocked read of 31 returns key
// - configuration takes effect after restart only
// - link frame 8 data, even parity, 1 stop
// - process status: top bit clear, fault flags
// - faulty data never delivered; flags informative
// - flag partner receive timeout
// - local timeout flags and zeroes input
// - index 31 reads zero while locked
// - timeout in 10 ms units, feature enabled
`ifndef STA_DEFINES_SVH
`define STA_DEFINES_SVH
// control byte layout
`define STA_CTRL_REG_BIT 7
`define STA_CTRL_WR_BIT  6
// register indices
`define STA_IDX_DIAG  6'h06
`define STA_IDX_TYPE  6'h08
`define STA_IDX_FWREV 6'h09
`define STA_IDX_CODE  6'h1F
`define STA_IDX_FEAT  6'h20
`define STA_IDX_BAUD  6'h21
`define STA_IDX_RCVTO 6'h22
`define STA_IDX_USER  6'h20
// values
`define STA_UNLOCK_KEY  16'h1235
`define STA_FEAT_RESET  16'h0007
`define STA_BAUD_RESET  16'h0003
`define STA_RCVTO_RESET 16'h0014
`define STA_FEAT_RCVTO_EN 0
// link frame marker (upper seven bits of header byte)
`define STA_HDR_MARK 7'h2A
// process-mode status bit positions
`define STA_ST_LOCALTO   4
`define STA_ST_PARTNERTO 3
`define STA_ST_SUMFAULT   2
`define STA_ST_OVERFLOW   1
`define STA_ST_FRAMEFAULT 0
// timing
`define STA_CLK_HZ      40000000
`define STA_BAUD_REF_HZ 4000000
`define STA_OVERSAMPLE  16
`define STA_TIMEOUT_UNIT_MS 10
`define STA_TICK_CYCLES (`STA_CLK_HZ / 1000 * `STA_TIMEOUT_UNIT_MS)
`define STA_CYC_PER_DIV (`STA_CLK_HZ / `STA_BAUD_REF_HZ * `STA_OVERSAMPLE)
`endif

// ### src/sta_param_mem.sv
// retained parameter store with registered read data
// assumes its own reset models loss of stored contents only
`timescale 1ns/1ps
module sta_param_mem #(
    parameter int                        WIDTH = 16,
    parameter int                        DEPTH = 32,
    parameter logic [DEPTH*WIDTH-1:0]    INIT  = '0
) (
    // clock and store reset
    input  wire logic                     clock,
    input  wire logic                     storeReset_n,
    // write port
    input  wire logic                     writeEn,
    input  wire logic [$clog2(DEPTH)-1:0] writeAddr,
    input  wire logic [WIDTH-1:0]         writeData,
    // read port, one cycle latency
    input  wire logic [$clog2(DEPTH)-1:0] readAddr,
    output logic      [WIDTH-1:0]         readData
);
    // storage and read register as one state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0]            rdata;
    } sta_mem_t;

    sta_mem_t state;       // registered
    sta_mem_t next_state;  // computed

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("sta_param_mem: bad geometry");
    end

    // write before read is not bypassed: read shows the old word
    always_comb begin
        next_state = state;
        next_state.rdata = state.words[readAddr];
        if (writeEn) begin
            next_state.words[writeAddr] = writeData;
        end
    end

    // defaults return only when the store itself is cleared
    always_ff @(posedge clock or negedge storeReset_n) begin
        if (!storeReset_n) begin
            state <= sta_mem_t'({INIT, {WIDTH{1'b0}}});
        end else begin
            state <= next_state;
        end
    end

    assign readData = state.rdata;
endmodule

// ### src/sta_pkg.sv
// types used by the terminal; the parameter store keeps its own
// assumes sta_defines.svh for all numeric constants
package sta_pkg;
    // access sequencer
    typedef enum logic [1:0] {ACC_BOOT, ACC_IDLE, ACC_READ} sta_acc_t;
    // serial receiver
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} sta_rx_t;
    // link fault and timeout flags
    typedef struct packed {
        logic localTo;
        logic partnerTo;
        logic checksumFaultFlag;
        logic bufferOverflowFlag;
        logic frameFaultFlag;
    } sta_flags_t;
    // configuration in force
    typedef struct packed {
        logic [15:0] feat;
        logic [15:0] baud;
        logic [15:0] rcvTo;
    } sta_cfg_t;
    // whole terminal state
    typedef struct packed {
        sta_acc_t    acc;
        logic [1:0]  bootStep;
        sta_cfg_t    cfg;
        logic [7:0]  ctrlSeen;
        logic [15:0] codeWord;
        logic [7:0]  statusByte;
        logic [15:0] inputWord;
        logic        rxMeta;
        logic        rxSync;
        sta_rx_t     rx;
        logic [15:0] rxCnt;
        logic [3:0]  rxBitNo;
        logic [8:0]  rxShift;
        logic [1:0]  rxPos;
        logic [23:0] rxFrame;
        logic [15:0] rxWord;
        logic        pendValid;
        sta_flags_t  flags;
        logic [23:0] tickCnt;
        logic [15:0] toCnt;
        logic        txBusy;
        logic [15:0] txCnt;
        logic [3:0]  txBitNo;
        logic [10:0] txShift;
        logic [1:0]  txPos;
        logic [31:0] txFrame;
        logic        txLine;
        logic [15:0] procWord;
    } sta_state_t;
endpackage

// ### src/sta_terminal.sv
// serial data-exchange terminal: control byte interpreter and link
// assumes process image ports are synchronous to clock; link pin is not
`timescale 1ns/1ps
`include "sta_defines.svh"
module sta_terminal #(
    parameter int          TICK_CYCLES = `STA_TICK_CYCLES,
    parameter logic [15:0] TYPE_ID     = 16'h0A5C, // arbitrary value
    parameter logic [15:0] FW_REV      = 16'h3030  // arbitrary value
) (
    // clock and resets
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        storeReset_n,
    // process image from the controller
    input  wire logic [7:0]  controlByte,
    input  wire logic [15:0] outputWord,
    // process image to the controller
    output logic      [7:0]  statusByte,
    output logic      [15:0] inputWord,
    // serial link
    input  wire logic        rxPin,
    output logic             txPin
);
    localparam int USER_DEPTH = 32;
    localparam logic [USER_DEPTH*16-1:0] USER_INIT =
        {{(USER_DEPTH-3)*16{1'b0}},
         `STA_RCVTO_RESET, `STA_BAUD_RESET, `STA_FEAT_RESET};

    if (TICK_CYCLES < 2 || TICK_CYCLES >= 2**24) begin : g_check
        $error("sta_terminal: TICK_CYCLES out of range");
    end

    sta_pkg::sta_state_t state;       // registered
    sta_pkg::sta_state_t next_state;  // computed

    // parameter store port
    logic        memWe;      // write strobe
    logic [4:0]  memWAddr;   // write index within user area
    logic [15:0] memWData;   // write data
    logic [4:0]  memRAddr;   // read index within user area
    logic [15:0] memRData;   // registered read data

    // helpers
    logic [15:0] bitLen;     // cycles per link bit
    logic [15:0] halfLen;    // half a bit, for start check
    logic [5:0]  regIdx;     // addressed register
    logic        isWrite;    // write access
    logic        regMode;    // register exchange selected
    logic        byteDone;   // receiver finished a character
    logic        byteOk;     // parity and stop good
    logic        frameGood;  // full frame, checksum good
    logic [7:0]  rxByte;     // received data bits
    logic [7:0]  txByte;     // byte now starting to send
    logic [7:0]  procStat;   // process-mode status byte

    sta_param_mem #(
        .WIDTH (16),
        .DEPTH (USER_DEPTH),
        .INIT  (USER_INIT)
    ) u_store (
        .clock        (clock),
        .storeReset_n (storeReset_n),
        .writeEn      (memWe),
        .writeAddr    (memWAddr),
        .writeData    (memWData),
        .readAddr     (memRAddr),
        .readData     (memRData)
    );

    // bit time from baud setting in force: ref/(16*(LB+1))
    always_comb begin
        bitLen  = 16'(`STA_CYC_PER_DIV * (32'(state.cfg.baud[7:0]) + 32'd1));
        halfLen = {1'b0, bitLen[15:1]};
    end

    // control byte fields
    always_comb begin
        regMode = controlByte[`STA_CTRL_REG_BIT];
        isWrite = controlByte[`STA_CTRL_WR_BIT];
        regIdx  = controlByte[5:0];
    end

    // store port: boot fetch, else register reads and unlocked writes of the user area
    always_comb begin
        memWe    = 1'b0;
        memWAddr = regIdx[4:0];
        memWData = outputWord;
        memRAddr = regIdx[4:0];
        if (state.acc == sta_pkg::ACC_BOOT) begin
            memRAddr = {3'b000, state.bootStep};
        end else if (state.acc == sta_pkg::ACC_IDLE && controlByte != state.ctrlSeen
                     && regMode && isWrite && regIdx >= `STA_IDX_USER) begin
            memWe = (state.codeWord == `STA_UNLOCK_KEY);
        end
    end

    // receive decode
    always_comb begin
        rxByte    = state.rxShift[7:0];
        byteDone  = state.rx == sta_pkg::RX_STOP && state.rxCnt == 16'h0000;
        byteOk    = byteDone && state.rxSync && !(^state.rxShift);
        frameGood = byteOk && state.rxPos == 2'd3
                    && (state.rxFrame[23:16] ^ state.rxFrame[15:8] ^ state.rxFrame[7:0]) == rxByte;
    end

    // process-mode status: top bits zero
    always_comb begin
        procStat = 8'h00;
        procStat[`STA_ST_LOCALTO]   = state.flags.localTo;
        procStat[`STA_ST_PARTNERTO] = state.flags.partnerTo;
        procStat[`STA_ST_SUMFAULT]   = state.flags.checksumFaultFlag;
        procStat[`STA_ST_OVERFLOW]   = state.flags.bufferOverflowFlag;
        procStat[`STA_ST_FRAMEFAULT] = state.flags.frameFaultFlag;
        txByte = state.txFrame[31:24];
    end

    // next state of the whole terminal
    always_comb begin
        next_state = state;

        // pin synchroniser, first stage feeds only the second
        next_state.rxMeta = rxPin;
        next_state.rxSync = state.rxMeta;

        // access sequencer
        unique case (state.acc)
            sta_pkg::ACC_BOOT: begin
                // settings in force are fetched only after restart
                next_state.bootStep = state.bootStep + 2'd1;
                if (state.bootStep == 2'd1) begin
                    next_state.cfg.feat = memRData;
                end
                if (state.bootStep == 2'd2) begin
                    next_state.cfg.baud = memRData;
                end
                if (state.bootStep == 2'd3) begin
                    next_state.cfg.rcvTo = memRData;
                    next_state.acc = sta_pkg::ACC_IDLE;
                end
            end
            sta_pkg::ACC_IDLE: begin
                if (controlByte != state.ctrlSeen) begin
                    next_state.ctrlSeen = controlByte;
                    if (regMode && isWrite) begin
                        // acknowledge: control with bit 6 cleared
                        next_state.statusByte = controlByte & 8'hBF;
                        next_state.inputWord  = 16'h0000;
                        if (regIdx == `STA_IDX_CODE) begin
                            next_state.codeWord = outputWord;
                        end
                    end else if (regMode && regIdx >= `STA_IDX_USER) begin
                        next_state.acc = sta_pkg::ACC_READ; // store answers next cycle
                    end else if (regMode) begin
                        // read ignores output word
                        next_state.statusByte = controlByte;
                        unique case (regIdx)
                            `STA_IDX_DIAG:  next_state.inputWord = {8'h00, procStat};
                            `STA_IDX_TYPE:  next_state.inputWord = TYPE_ID;
                            `STA_IDX_FWREV: next_state.inputWord = FW_REV;
                            `STA_IDX_CODE: begin
                                // key shows only while unlocked
                                next_state.inputWord =
                                    (state.codeWord == `STA_UNLOCK_KEY) ? `STA_UNLOCK_KEY : 16'h0000;
                            end
                            default:        next_state.inputWord = 16'h0000;
                        endcase
                    end
                end
            end
            sta_pkg::ACC_READ: begin
                next_state.statusByte = state.ctrlSeen;
                next_state.inputWord  = memRData;
                next_state.acc = sta_pkg::ACC_IDLE;
            end
        endcase

        // process mode: status and data follow the link every cycle
        if (state.acc != sta_pkg::ACC_BOOT && !state.ctrlSeen[`STA_CTRL_REG_BIT]
            && !regMode && controlByte == state.ctrlSeen) begin
            next_state.statusByte = procStat;
            next_state.inputWord  = state.flags.localTo ? 16'h0000 : state.rxWord;
            next_state.procWord   = outputWord;
            next_state.pendValid  = 1'b0;
        end

        // receiver
        next_state.rxCnt = (state.rxCnt == 16'h0000) ? 16'h0000 : state.rxCnt - 16'h0001;
        unique case (state.rx)
            sta_pkg::RX_IDLE: begin
                if (!state.rxSync) begin
                    next_state.rx    = sta_pkg::RX_START;
                    next_state.rxCnt = halfLen;
                end
            end
            sta_pkg::RX_START: begin
                if (state.rxCnt == 16'h0000) begin
                    // glitch shorter than half a bit is dropped
                    next_state.rx      = state.rxSync ? sta_pkg::RX_IDLE : sta_pkg::RX_BITS;
                    next_state.rxCnt   = bitLen - 16'h0001;
                    next_state.rxBitNo = 4'h0;
                end
            end
            sta_pkg::RX_BITS: begin
                if (state.rxCnt == 16'h0000) begin
                    // lsb first, parity ends up in bit 8
                    next_state.rxShift = {state.rxSync, state.rxShift[8:1]};
                    next_state.rxBitNo = state.rxBitNo + 4'h1;
                    next_state.rxCnt   = bitLen - 16'h0001;
                    if (state.rxBitNo == 4'h8) begin
                        next_state.rx = sta_pkg::RX_STOP;
                    end
                end
            end
            sta_pkg::RX_STOP: begin
                if (state.rxCnt == 16'h0000) begin
                    next_state.rx = sta_pkg::RX_IDLE;
                end
            end
        endcase

        // frame assembly: header, high, low, checksum
        if (byteDone && !byteOk) begin
            next_state.flags.frameFaultFlag = 1'b1;
            next_state.rxPos = 2'd0;
        end else if (byteOk) begin
            next_state.rxFrame = {state.rxFrame[15:0], rxByte};
            next_state.rxPos   = state.rxPos + 2'd1;
            if (state.rxPos == 2'd0 && rxByte[7:1] != `STA_HDR_MARK) begin
                next_state.rxPos = 2'd0; // resync on header
            end
            if (state.rxPos == 2'd3 && !frameGood) begin
                next_state.flags.checksumFaultFlag = 1'b1;
            end
        end

        // timeout: 10 ms ticks since last good frame
        next_state.tickCnt = state.tickCnt + 24'h000001;
        if (state.tickCnt == 24'(TICK_CYCLES - 1)) begin
            next_state.tickCnt = 24'h000000;
            if (state.toCnt != 16'hFFFF) begin
                next_state.toCnt = state.toCnt + 16'h0001;
            end
        end
        if (state.cfg.feat[`STA_FEAT_RCVTO_EN] && state.cfg.rcvTo != 16'h0000
            && state.toCnt >= state.cfg.rcvTo) begin
            next_state.flags.localTo = 1'b1;
        end

        // delivery of a good frame; clears the quality flags, but sets overflow again if a held-back frame is still pending
        if (frameGood) begin
            next_state.tickCnt = 24'h000000;
            next_state.toCnt   = 16'h0000;
            next_state.flags.localTo   = 1'b0;
            next_state.flags.partnerTo = state.rxFrame[16];
            // these clears win over a checksum or frame fault in the same cycle, none can coincide
            next_state.flags.checksumFaultFlag  = 1'b0;
            next_state.flags.frameFaultFlag     = 1'b0;
            next_state.flags.bufferOverflowFlag = 1'b0;
            next_state.rxWord = state.rxFrame[15:0];
            // data held back while registers own the input word
            if (state.ctrlSeen[`STA_CTRL_REG_BIT]) begin
                next_state.pendValid = 1'b1;
                next_state.flags.bufferOverflowFlag = state.pendValid;
            end
        end

        // transmitter: frames back to back
        next_state.txCnt = (state.txCnt == 16'h0000) ? 16'h0000 : state.txCnt - 16'h0001;
        if (!state.txBusy) begin
            next_state.txFrame = {`STA_HDR_MARK, state.flags.localTo,
                                  state.procWord,
                                  state.procWord[15:8] ^ state.procWord[7:0]
                                  ^ {`STA_HDR_MARK, state.flags.localTo}};
            next_state.txBusy  = state.acc != sta_pkg::ACC_BOOT;
            next_state.txPos   = 2'd0;
            next_state.txBitNo = 4'h0;
        end else if (state.txBitNo == 4'h0) begin
            // start, 8 data, even parity, stop
            next_state.txShift = {1'b1, ^txByte, txByte, 1'b0};
            next_state.txBitNo = 4'h1;
            next_state.txCnt   = bitLen - 16'h0001;
        end else if (state.txCnt == 16'h0000) begin
            next_state.txShift = {1'b1, state.txShift[10:1]};
            next_state.txBitNo = state.txBitNo + 4'h1;
            next_state.txCnt   = bitLen - 16'h0001;
            if (state.txBitNo == 4'hB) begin
                next_state.txBitNo = 4'h0;
                next_state.txFrame = {state.txFrame[23:0], 8'h00};
                next_state.txPos   = state.txPos + 2'd1;
                next_state.txBusy  = state.txPos != 2'd3;
            end
        end
        next_state.txLine = (next_state.txBusy && next_state.txBitNo != 4'h0)
                            ? next_state.txShift[0] : 1'b1;
    end

    // register the whole state; line idles high
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state          <= '0;
            state.acc      <= sta_pkg::ACC_BOOT;
            state.rx       <= sta_pkg::RX_IDLE;
            state.rxMeta   <= 1'b1;
            state.rxSync   <= 1'b1;
            state.txShift  <= 11'h7FF;
            state.txLine   <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign statusByte = state.statusByte;
    assign inputWord  = state.inputWord;
    assign txPin      = state.txLine;
endmodule
